//--- mtu_defines.vh
`ifndef MTU_DEFINES_VH
`define MTU_DEFINES_VH
// ----------------------------------------
// Register word indices (byte address / 4)
// ----------------------------------------
`define MTU_IDX_START_A 6'h00
`define MTU_IDX_START_B 6'h01
`define MTU_IDX_UPDOWN 6'h02
`define MTU_IDX_ONESHOT 6'h03
`define MTU_IDX_TRGSEL 6'h04
`define MTU_IDX_REQ 6'h05
`define MTU_IDX_CTRL 6'h06
`define MTU_IDX_A_MODE 6'h08
`define MTU_IDX_A_CNT 6'h10
`define MTU_IDX_B_MODE 6'h18
`define MTU_IDX_B_CNT 6'h20
// ----------------------------------------
// Mode encodings and fields
// ----------------------------------------
`define MTU_M_TIMER 2'h0
`define MTU_M_EVENT 2'h1
`define MTU_M_ONESHOT 2'h2
`define MTU_M_PWM 2'h3
`define MTU_M_MEASURE 2'h2
`define MTU_MODE_LSB 0
`define MTU_FN_LSB 2
`define MTU_OVF_BIT 4
`define MTU_CTRL_PRESC_LSB 8
// ----------------------------------------
// Reset values and constants
// ----------------------------------------
`define MTU_CNT_RST 16'h0000
`define MTU_CNT_MAX 16'hFFFF
`define MTU_CNT_ZERO 16'h0000
`define MTU_CTRL_RST 4'h0
`define MTU_PRESC_RST 8'h00
`define MTU_MOTOR_MASK 5'h16
`endif

//--- mtu_monitor.sv
`timescale 1ns/100ps
// ----------------------------------------
// Port-level checker for the timer block
// ----------------------------------------
module mtu_monitor #(
  parameter NA = 5,
  parameter NB = 6
) (
  input wire i_clk,
  input wire i_rst,
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [7:0] i_paddr,
  input wire [31:0] i_pwdata,
  input wire o_pready,
  input wire [31:0] o_prdata,
  input wire o_pslverr,
  input wire [NA-1:0] i_timer_input_pin,
  input wire [NB-1:0] i_measure_pin,
  input wire i_shutdown_n,
  input wire [NA-1:0] o_timer_output_pin,
  input wire [NA-1:0] o_timer_output_oe,
  input wire [NA+NB-1:0] o_request_flag
);
  // Bus phase decode
  wire setup = i_psel && !i_penable;
  wire clr_wr = i_psel && i_penable && o_pready && i_pwrite
    && i_paddr == 8'h14;
  wire [5:0] idx = i_paddr[7:2];
  // Word indices that hold a register
  wire mapped = idx < 6'h07 || (idx < 6'h18 && idx[2:0] < 3'h5)
    || (idx >= 6'h18 && idx < 6'h28 && idx[2:0] < 3'h6);

  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);

  sequence s_answer;
    o_pready ##1 !o_pready;
  endsequence

  chk_ready_pulse: assert property (setup |=> s_answer)
    else $error("ready not a single access cycle");
  chk_ready_cause: assert property (o_pready |-> $past(setup))
    else $error("ready without setup");
  chk_unmapped_err: assert property (
    setup |=> o_pslverr == !$past(mapped))
    else $error("slave error does not match address");
  chk_write_rdata: assert property (
    setup && i_pwrite |=> o_prdata == 32'h0)
    else $error("read data not zero on write");
  chk_reset_quiet: assert property ($fell(i_rst) |->
    o_request_flag == 0 && o_timer_output_pin == 0)
    else $error("outputs active after reset");
  chk_flag_sticky: assert property (!$past(clr_wr) |->
    ($past(o_request_flag) & ~o_request_flag) == 0)
    else $error("request flag cleared without write");
  chk_oe_fixed: assert property (
    o_timer_output_oe[0] && o_timer_output_oe[3])
    else $error("non-motor output enable dropped");
  chk_oe_restore: assert property (
    i_shutdown_n [*5] |-> &o_timer_output_oe)
    else $error("output enable low without shutdown");
  chk_float_cause: assert property (
    $fell(o_timer_output_oe[1]) |-> !$past(i_shutdown_n, 2)
    || !$past(i_shutdown_n, 3) || !$past(i_shutdown_n, 4))
    else $error("motor output floated without pin low");
endmodule

bind mtu_top mtu_monitor #(.NA(NA), .NB(NB)) i_mon (
  .i_clk(i_clk), .i_rst(i_rst), .i_psel(i_psel),
  .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
  .i_pwdata(i_pwdata), .o_pready(o_pready), .o_prdata(o_prdata),
  .o_pslverr(o_pslverr), .i_timer_input_pin(i_timer_input_pin),
  .i_measure_pin(i_measure_pin), .i_shutdown_n(i_shutdown_n),
  .o_timer_output_pin(o_timer_output_pin),
  .o_timer_output_oe(o_timer_output_oe),
  .o_request_flag(o_request_flag));

//--- mtu_pins.sv
`timescale 1ns/100ps
// ----------------------------------------
// Far-side pins: triggers, pulses, shutdown
// ----------------------------------------
module mtu_pins (
  input wire i_clk,
  output reg [4:0] o_trig,
  output reg [5:0] o_meas,
  output reg o_shutdown_n
);
  // Idle pin levels
  initial begin
    o_trig = 5'h00;
    o_meas = 6'h00;
    o_shutdown_n = 1'b1;
  end
  // One-clock trigger, then a quiet gap before any retrigger
  task trig(input int ch);
    begin
      @(posedge i_clk);
      o_trig[ch] <= 1'b1;
      @(posedge i_clk);
      o_trig[ch] <= 1'b0;
      @(posedge i_clk);
    end
  endtask
  // Measured pulse level
  task meas(input int ch, input bit v);
    begin
      @(posedge i_clk);
      o_meas[ch] <= v;
    end
  endtask
  // Shutdown pin level
  task shut(input bit v);
    begin
      @(posedge i_clk);
      o_shutdown_n <= v;
    end
  endtask
endmodule

//--- mtu_top.v
// Design decisions made here: the address map and the APB interface to the registers.
`timescale 1ns/100ps
`include "mtu_defines.vh"

// Notes on behaviour
// (R1) Five general and six measurement channels, each with its own start bit.
// (R2) All channels halted after reset; counting begins when start bit written 1.
// (R3) Software changes mode, direction, trigger settings only while channel stopped.
// (R4) General timer read: live count, FFFFh while reloading, written value if stopped.
// (R5) Event counter reload read: FFFFh after underflow, 0000h after overflow.
// (R6) Stopping one-shot reloads, drives output low, flags request one clock later.
// (R7) External one-shot trigger starts pulse within one count-source clock.
// (R8) Entering one-shot from timer or event mode sets the request flag.
// (R9) One-shot retrigger: one more count, reload set value, keep counting.
// (R10) Trigger source leaves one count-source cycle between retriggers.
// (R11) External retrigger not within 300 ns before count reaches 0000h.
// (R12) Entering PWM from timer or event mode sets the request flag.
// (R13) Stopping PWM: high output falls and flags; low output left alone.
// (R14) Measurement timer read: live count, FFFFh reloading, written value if stopped.
// (R15) Mode write while measuring clears overflow flag set a tick earlier.
// (R16) Measurement counter starts undefined; overflow may flag before first edge.
// (R17) First valid edge after start captures junk and raises no request.
// (R18) Changing measure function while running flags; same value leaves flag.
// (R19) Pulse-width measurement captures every successive width continuously.
// (R20) Overflow coinciding with valid edge gives one request; edge ignored.
// (R21) Motor outputs float on low shutdown pin when all four enables set.
// (R22) Software avoids secondary reload writes near carrier timer underflow.
// (R23) Each channel sets its sticky request flag; software clears it.
module mtu_top #(
  parameter NA = 5,
  parameter NB = 6
) (
  input wire i_clk,
  input wire i_rst,
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [7:0] i_paddr,
  input wire [31:0] i_pwdata,
  output reg o_pready,
  output reg [31:0] o_prdata,
  output reg o_pslverr,
  input wire [NA-1:0] i_timer_input_pin,
  input wire [NB-1:0] i_measure_pin,
  input wire i_shutdown_n,
  output wire [NA-1:0] o_timer_output_pin,
  output reg [NA-1:0] o_timer_output_oe,
  output reg [NA+NB-1:0] o_request_flag
);

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  wire [5:0] idx = i_paddr[7:2];
  wire wr = i_psel & i_penable & o_pready & i_pwrite;
  wire [15:0] wd = i_pwdata[15:0];
  wire [5:0] a_mi = idx - `MTU_IDX_A_MODE;
  wire [5:0] a_ci = idx - `MTU_IDX_A_CNT;
  wire [5:0] b_mi = idx - `MTU_IDX_B_MODE;
  wire [5:0] b_ci = idx - `MTU_IDX_B_CNT;

  reg [NA-1:0] count_start_register;
  reg [NB-1:0] second_count_start_register;
  reg [NA-1:0] up_down_select_register;
  reg [NA-1:0] trigger_select_register;
  reg [3:0] ctrl_reg;
  reg [7:0] presc_reg;
  reg [7:0] div_reg;
  reg tick_reg;
  reg [NA-1:0] ta_s1, ta_s2, ta_s3;
  reg [NB-1:0] tb_s1, tb_s2, tb_s3;
  reg sd_s1, sd_s2;

  wire [NA-1:0] ta_rise = ta_s2 & ~ta_s3;
  wire [NB-1:0] tb_rise = tb_s2 & ~tb_s3;
  wire [NB-1:0] tb_fall = ~tb_s2 & tb_s3;
  wire [NA-1:0] sw_trig;
  assign sw_trig = (wr && idx == `MTU_IDX_ONESHOT) ? wd[NA-1:0] : {NA{1'b0}};

  wire [NA*16-1:0] a_rd;
  wire [NA*2-1:0] a_md;
  wire [NA-1:0] a_set;
  wire [NB*16-1:0] b_rd;
  wire [NB*5-1:0] b_md;
  wire [NB-1:0] b_set;

  // ----------------------------------------
  // Pin synchronisers and edge history
  // ----------------------------------------
  always @(posedge i_clk) begin
    if (i_rst) begin
      ta_s1 <= {NA{1'b0}};
      ta_s2 <= {NA{1'b0}};
      ta_s3 <= {NA{1'b0}};
      tb_s1 <= {NB{1'b0}};
      tb_s2 <= {NB{1'b0}};
      tb_s3 <= {NB{1'b0}};
      sd_s1 <= 1'b1;
      sd_s2 <= 1'b1;
    end else begin
      ta_s1 <= i_timer_input_pin;
      ta_s2 <= ta_s1;
      ta_s3 <= ta_s2;
      tb_s1 <= i_measure_pin;
      tb_s2 <= tb_s1;
      tb_s3 <= tb_s2;
      sd_s1 <= i_shutdown_n;
      sd_s2 <= sd_s1;
    end
  end

  // ----------------------------------------
  // Count source divider
  // ----------------------------------------
  always @(posedge i_clk) begin
    if (i_rst) begin
      div_reg <= `MTU_PRESC_RST;
      tick_reg <= 1'b0;
    end else if (div_reg >= presc_reg) begin
      div_reg <= 8'h00;
      tick_reg <= 1'b1;
    end else begin
      div_reg <= div_reg + 8'h01;
      tick_reg <= 1'b0;
    end
  end

  // ----------------------------------------
  // Shared control registers
  // ----------------------------------------
  always @(posedge i_clk) begin
    if (i_rst) begin
      count_start_register <= {NA{1'b0}}; // R2
      second_count_start_register <= {NB{1'b0}}; // R2
      up_down_select_register <= {NA{1'b0}};
      trigger_select_register <= {NA{1'b0}};
      ctrl_reg <= `MTU_CTRL_RST;
      presc_reg <= `MTU_PRESC_RST;
    end else if (wr) begin
      case (idx)
        `MTU_IDX_START_A: count_start_register <= wd[NA-1:0]; // R1
        `MTU_IDX_START_B: second_count_start_register <= wd[NB-1:0]; // R1
        `MTU_IDX_UPDOWN: up_down_select_register <= wd[NA-1:0];
        `MTU_IDX_TRGSEL: trigger_select_register <= wd[NA-1:0];
        `MTU_IDX_CTRL: begin
          ctrl_reg <= wd[3:0];
          presc_reg <= wd[`MTU_CTRL_PRESC_LSB+:8];
        end
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // Request flags and shutdown
  // ----------------------------------------
  wire [NA+NB-1:0] req_clr;
  assign req_clr = (wr && idx == `MTU_IDX_REQ) ? wd[NA+NB-1:0] : {(NA+NB){1'b0}};
  wire sd_act = ~sd_s2 & (&ctrl_reg);

  // Set beats a simultaneous clear
  always @(posedge i_clk) begin
    if (i_rst) begin
      o_request_flag <= {(NA+NB){1'b0}};
      o_timer_output_oe <= {NA{1'b1}};
    end else begin
      o_request_flag <= (o_request_flag & ~req_clr) | {b_set, a_set}; // R23
      o_timer_output_oe <= sd_act ? ~`MTU_MOTOR_MASK : {NA{1'b1}}; // R21
    end
  end

  // ----------------------------------------
  // General channels
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < NA; g = g + 1) begin : gen_a
      reg [1:0] md;
      reg [15:0] cnt, rel, rldv;
      reg out, rld, run, pend, stp_d, set;
      wire st = count_start_register[g];
      wire wm = wr && a_mi == g;
      wire wc = wr && a_ci == g;
      wire ev = ta_rise[g];
      wire up = up_down_select_register[g];
      wire trig = trigger_select_register[g] ? ev : sw_trig[g];
      always @(posedge i_clk) begin
        if (i_rst) begin
          md <= `MTU_M_TIMER;
          cnt <= `MTU_CNT_RST;
          rel <= `MTU_CNT_RST;
          rldv <= `MTU_CNT_MAX;
          out <= 1'b0;
          rld <= 1'b0;
          run <= 1'b0;
          pend <= 1'b0;
          stp_d <= 1'b0;
          set <= 1'b0;
        end else begin
          rld <= 1'b0;
          stp_d <= 1'b0;
          set <= stp_d; // R6
          if (wm) begin
            md <= wd[1:0];
            if (!md[1] && wd[1])
              set <= 1'b1; // R8 R12
          end
          if (wc) begin
            rel <= wd;
            if (!st)
              cnt <= wd; // R4
          end
          if (!st) begin
            run <= 1'b0;
            pend <= 1'b0;
            if (run && md == `MTU_M_ONESHOT) begin
              cnt <= rel; // R6
              out <= 1'b0; // R6
              stp_d <= 1'b1; // R6
            end else if (md == `MTU_M_PWM && out) begin
              out <= 1'b0; // R13
              set <= 1'b1; // R13
            end
          end else begin
            case (md)
              `MTU_M_TIMER: if (tick_reg) begin
                if (cnt == `MTU_CNT_ZERO) begin
                  cnt <= rel;
                  rld <= 1'b1; // R4
                  rldv <= `MTU_CNT_MAX; // R4
                  set <= 1'b1; // R23
                end else begin
                  cnt <= cnt - 16'h0001;
                end
              end
              `MTU_M_EVENT: if (ev) begin
                if (up && cnt == `MTU_CNT_MAX) begin
                  cnt <= rel;
                  rld <= 1'b1;
                  rldv <= `MTU_CNT_ZERO; // R5
                  set <= 1'b1;
                end else if (!up && cnt == `MTU_CNT_ZERO) begin
                  cnt <= rel;
                  rld <= 1'b1;
                  rldv <= `MTU_CNT_MAX; // R5
                  set <= 1'b1;
                end else begin
                  cnt <= up ? cnt + 16'h0001 : cnt - 16'h0001;
                end
              end
              `MTU_M_ONESHOT: begin
                if (trig)
                  pend <= 1'b1;
                if (tick_reg && pend) begin
                  pend <= trig;
                  cnt <= rel; // R9
                  run <= 1'b1;
                  out <= 1'b1; // R7
                end else if (tick_reg && run) begin
                  if (cnt <= 16'h0001) begin
                    cnt <= rel;
                    run <= 1'b0;
                    out <= 1'b0;
                    set <= 1'b1; // R23
                  end else begin
                    cnt <= cnt - 16'h0001;
                  end
                end
              end
              default: if (tick_reg) begin
                if (cnt == `MTU_CNT_ZERO) begin
                  out <= ~out;
                  cnt <= out ? ~rel : rel;
                  if (out)
                    set <= 1'b1; // R23
                end else begin
                  cnt <= cnt - 16'h0001;
                end
              end
            endcase
          end
        end
      end
      assign a_rd[g*16+:16] = rld ? rldv : cnt; // R4 R5
      assign a_md[g*2+:2] = md;
      assign a_set[g] = set;
      assign o_timer_output_pin[g] = out;
    end
  endgenerate

  // ----------------------------------------
  // Measurement channels
  // ----------------------------------------
  generate
    for (g = 0; g < NB; g = g + 1) begin : gen_b
      reg [3:0] md;
      reg [15:0] cnt, rel;
      reg rld, ovf, ovf_old, first, prev_st, set;
      wire st = second_count_start_register[g];
      wire wm = wr && b_mi == g;
      wire wc = wr && b_ci == g;
      wire [1:0] fn = md[`MTU_FN_LSB+:2];
      wire ve = fn[1] ? (tb_rise[g] | tb_fall[g]) :
        (fn[0] ? tb_rise[g] : tb_fall[g]); // R19
      wire step = md[0] ? tb_rise[g] : tick_reg;
      always @(posedge i_clk) begin
        if (i_rst) begin
          md <= 4'h0;
          cnt <= `MTU_CNT_RST;
          rel <= `MTU_CNT_RST;
          rld <= 1'b0;
          ovf <= 1'b0;
          ovf_old <= 1'b0;
          first <= 1'b0;
          prev_st <= 1'b0;
          set <= 1'b0;
        end else begin
          rld <= 1'b0;
          set <= 1'b0;
          prev_st <= st;
          if (wc) begin
            rel <= wd;
            if (!st)
              cnt <= wd; // R14
          end
          if (st) begin
            if (md[1:0] == `MTU_M_MEASURE) begin
              if (tick_reg)
                ovf_old <= ovf;
              if (tick_reg && cnt == `MTU_CNT_MAX) begin
                cnt <= `MTU_CNT_ZERO; // R16
                ovf <= 1'b1;
                set <= 1'b1; // R20
              end else begin
                if (tick_reg)
                  cnt <= cnt + 16'h0001;
                if (ve) begin
                  rel <= cnt; // R17
                  cnt <= `MTU_CNT_ZERO; // R19
                  first <= 1'b0;
                  if (!first)
                    set <= 1'b1; // R17
                end
              end
            end else if (step) begin
              if (cnt == `MTU_CNT_ZERO) begin
                cnt <= rel;
                rld <= 1'b1; // R14
                set <= 1'b1; // R23
              end else begin
                cnt <= cnt - 16'h0001;
              end
            end
          end
          if (wm) begin
            md <= wd[3:0];
            if (st && wd[`MTU_FN_LSB+:2] != fn)
              set <= 1'b1; // R18
            if (st && ovf_old) begin
              ovf <= 1'b0; // R15
              ovf_old <= 1'b0;
            end
          end
          if (st && !prev_st)
            first <= 1'b1; // R17
        end
      end
      assign b_rd[g*16+:16] = (md[1:0] == `MTU_M_MEASURE) ? rel :
        (rld ? `MTU_CNT_MAX : cnt); // R14
      assign b_md[g*5+:5] = {ovf, md};
      assign b_set[g] = set;
    end
  endgenerate

  // ----------------------------------------
  // Read mux, latched in the setup cycle
  // ----------------------------------------
  reg [31:0] rd_next;
  reg err_next;
  always @* begin
    rd_next = 32'h00000000;
    err_next = 1'b0;
    if (a_mi < NA)
      rd_next[1:0] = a_md[a_mi*2+:2];
    else if (a_ci < NA)
      rd_next[15:0] = a_rd[a_ci*16+:16];
    else if (b_mi < NB)
      rd_next[4:0] = b_md[b_mi*5+:5];
    else if (b_ci < NB)
      rd_next[15:0] = b_rd[b_ci*16+:16];
    else begin
      case (idx)
        `MTU_IDX_START_A: rd_next[NA-1:0] = count_start_register;
        `MTU_IDX_START_B: rd_next[NB-1:0] = second_count_start_register;
        `MTU_IDX_UPDOWN: rd_next[NA-1:0] = up_down_select_register;
        `MTU_IDX_ONESHOT: rd_next = 32'h00000000;
        `MTU_IDX_TRGSEL: rd_next[NA-1:0] = trigger_select_register;
        `MTU_IDX_REQ: rd_next[NA+NB-1:0] = o_request_flag;
        `MTU_IDX_CTRL: rd_next[15:0] = {presc_reg, 4'h0, ctrl_reg};
        default: err_next = 1'b1;
      endcase
    end
  end

  // APB answer: ready in the first access cycle
  always @(posedge i_clk) begin
    if (i_rst) begin
      o_pready <= 1'b0;
      o_prdata <= 32'h00000000;
      o_pslverr <= 1'b0;
    end else begin
      o_pready <= i_psel & ~i_penable;
      if (i_psel & ~i_penable) begin
        o_prdata <= i_pwrite ? 32'h00000000 : rd_next;
        o_pslverr <= err_next;
      end
    end
  end

endmodule

//--- mtu_top_bench.sv
`timescale 1ns/100ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin fails++; \
  $display("ERROR at %0t got %h exp %h", $time, g, e); end end
module mtu_top_bench;
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg psel = 1'b0;
  reg penable = 1'b0;
  reg pwrite = 1'b0;
  reg [7:0] paddr = 8'h00;
  reg [31:0] pwdata = 32'h0;
  wire pready;
  wire [31:0] prdata;
  wire pslverr;
  wire [4:0] trig;
  wire [5:0] meas;
  wire sd_n;
  wire [4:0] tout;
  wire [4:0] oe;
  wire [10:0] flag;
  wire [15:0] mon = {flag, tout};
  reg [31:0] r;
  reg err;
  int fails = 0;
  int n_compared = 0;

  initial forever #12.5 clk = ~clk;

  mtu_top i_dut (.i_clk(clk), .i_rst(rst), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_pready(pready), .o_prdata(prdata),
    .o_pslverr(pslverr), .i_timer_input_pin(trig),
    .i_measure_pin(meas), .i_shutdown_n(sd_n),
    .o_timer_output_pin(tout), .o_timer_output_oe(oe),
    .o_request_flag(flag));
  mtu_pins i_pins (.i_clk(clk), .o_trig(trig), .o_meas(meas),
    .o_shutdown_n(sd_n));

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task finish_test;
    begin
      $display("Compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) begin
        $display("Result: passed");
      end else begin
        $display("Result: failed");
      end
      $finish;
    end
  endtask
  // One bus transfer, held until ready is sampled high
  task xfer(input bit w, input [7:0] a, input [31:0] d);
    int k;
    begin
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      k = 0;
      do begin
        @(posedge clk);
        k++;
      end while (pready !== 1'b1 && k < 20);
      if (pready !== 1'b1) begin
        fails++;
        finish_test;
      end
      r = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      repeat (2) @(posedge clk);
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task rd(input [7:0] a);
    xfer(1'b0, a, 32'h0);
  endtask
  task clr;
    wr(8'h14, 32'h7FF);
  endtask
  // Bounded wait for an output or flag bit to go high
  task wait_hi(input int b, input int n);
    int k;
    begin
      k = 0;
      while (mon[b] !== 1'b1 && k < n) begin
        @(posedge clk);
        k++;
      end
      if (mon[b] !== 1'b1) begin
        fails++;
        finish_test;
      end
    end
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(8'h00);
    `CHK(r, 32'h0)
    rd(8'h04);
    `CHK(r, 32'h0)
    `CHK(flag, 11'h000)
    rd(8'h1C);
    `CHK({err, r}, 33'h100000000)
    // Timer mode readback and underflow request
    wr(8'h40, 32'h5);
    rd(8'h40);
    `CHK(r[15:0], 16'h0005)
    wr(8'h00, 32'h1);
    wait_hi(5, 40);
    wr(8'h00, 32'h0);
    clr;
    `CHK(flag, 11'h000)
    // Mode entry requests
    wr(8'h24, 32'h2);
    wr(8'h28, 32'h3);
    `CHK(flag[2:1], 2'h3)
    clr;
    wr(8'h24, 32'h2);
    `CHK(flag, 11'h000)
    // One-shot stopped mid-count
    wr(8'h44, 32'h64);
    wr(8'h00, 32'h2);
    wr(8'h0C, 32'h2);
    wait_hi(1, 10);
    wr(8'h00, 32'h0);
    repeat (2) @(posedge clk);
    `CHK(tout[1], 1'b0)
    `CHK(flag[1], 1'b1)
    rd(8'h44);
    `CHK(r[15:0], 16'h0064)
    // Pin-triggered one-shot
    wr(8'h2C, 32'h2);
    wr(8'h4C, 32'h32);
    wr(8'h10, 32'h8);
    wr(8'h00, 32'h8);
    i_pins.trig(3);
    wait_hi(3, 6);
    wr(8'h00, 32'h0);
    clr;
    // PWM stopped while high
    wr(8'h48, 32'h8);
    wr(8'h00, 32'h4);
    wait_hi(2, 20);
    wr(8'h00, 32'h0);
    repeat (2) @(posedge clk);
    `CHK(tout[2], 1'b0)
    `CHK(flag[2], 1'b1)
    clr;
    // Width measurement across successive edges
    wr(8'h60, 32'hA);
    wr(8'h04, 32'h1);
    clr;
    i_pins.meas(0, 1'b1);
    repeat (8) @(posedge clk);
    wr(8'h60, 32'hA);
    `CHK(flag[5], 1'b0)
    i_pins.meas(0, 1'b0);
    repeat (8) @(posedge clk);
    `CHK(flag[5], 1'b1)
    clr;
    i_pins.meas(0, 1'b1);
    repeat (8) @(posedge clk);
    `CHK(flag[5], 1'b1)
    clr;
    wr(8'h60, 32'h6);
    `CHK(flag[5], 1'b1)
    wr(8'h04, 32'h0);
    // Overflow before any edge, cleared by mode rewrite
    wr(8'h64, 32'h2);
    wr(8'h84, 32'hFFF0);
    wr(8'h04, 32'h2);
    clr;
    repeat (30) @(posedge clk);
    `CHK(flag[6], 1'b1)
    rd(8'h64);
    `CHK(r[4], 1'b1)
    wr(8'h64, 32'h2);
    rd(8'h64);
    `CHK(r[4], 1'b0)
    wr(8'h04, 32'h0);
    wr(8'h88, 32'h1234);
    rd(8'h88);
    `CHK(r[15:0], 16'h1234)
    // Shutdown with partial and full enables
    wr(8'h18, 32'h7);
    i_pins.shut(1'b0);
    repeat (6) @(posedge clk);
    `CHK(oe, 5'h1F)
    wr(8'h18, 32'hF);
    `CHK(oe, 5'h09)
    i_pins.shut(1'b1);
    repeat (6) @(posedge clk);
    `CHK(oe, 5'h1F)
    finish_test;
  end
endmodule
